// File: mrr_cfg.svh
`ifndef MRR_CFG_SVH
`define MRR_CFG_SVH

// Register indices; the byte address is four times the index.
`define MRR_IDX_DIAG_FIRST 8'h57
`define MRR_IDX_DIAG_SECOND 8'h58
`define MRR_IDX_AUX_ZERO 8'h59
`define MRR_IDX_AUX_ONE 8'h5a
`define MRR_IDX_AUX_TWO 8'h5b
`define MRR_IDX_DIAG_CONFIG 8'h60
`define MRR_IDX_SIDE_CONFIG 8'h61
`define MRR_IDX_FRESH 8'h62

// Result field: 14 bits placed in bits 15:2.
`define MRR_RESULT_WIDTH 14
`define MRR_RESULT_LSB 2
`define MRR_RESULT_RESET 14'h0000

// Diagnostic configuration fields.
`define MRR_DIAG_FIRST_LSB 0
`define MRR_DIAG_SECOND_LSB 8
`define MRR_DIAG_CONFIG_RESET 32'h0000_0000

// Side-channel configuration fields.
`define MRR_PIN_CFG_LSB 0
`define MRR_ENABLE_LSB 8
`define MRR_RATIO_LSB 16
`define MRR_SIDE_CONFIG_RESET 32'h0000_0000

// Fresh-result flags.
`define MRR_FRESH_DIAG_FIRST 0
`define MRR_FRESH_DIAG_SECOND 1
`define MRR_FRESH_AUX_LSB 2

// Widths and counts.
`define MRR_INDEX_WIDTH 4
`define MRR_CHOICE_WIDTH 4
`define MRR_AUX_COUNT 3

`endif

// File: mrr_pkg.sv
`include "mrr_cfg.svh"

package mrr_pkg;

    // Kind of converter result on the result strobe.
    typedef enum logic {
        MRR_KIND_DIAG,
        MRR_KIND_AUX
    } mrr_kind_type;

    // One converter result, offered for one cycle.
    typedef struct packed {
        logic valid;
        mrr_kind_type kind;
        logic [`MRR_INDEX_WIDTH-1:0] index;
        logic [`MRR_RESULT_WIDTH-1:0] data;
    } mrr_sample_type;

    // Phase of the bus slave.
    typedef enum logic {
        MRR_PHASE_IDLE,
        MRR_PHASE_DONE
    } mrr_phase_type;

endpackage

// File: mrr_readback.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "mrr_cfg.svh"

module mrr_readback #(
    parameter int ADDR_WIDTH = 12,
    parameter int AUX_COUNT = `MRR_AUX_COUNT,
    parameter int CHOICE_WIDTH = `MRR_CHOICE_WIDTH
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter results.
    input wire mrr_pkg::mrr_sample_type sample,
    // Settings toward the converter sequencer.
    output logic [CHOICE_WIDTH-1:0] diag_choice_first,
    output logic [CHOICE_WIDTH-1:0] diag_choice_second,
    output logic [AUX_COUNT-1:0] side_pin_config,
    output logic [AUX_COUNT-1:0] side_measure_enable,
    output logic [AUX_COUNT-1:0] side_ratio_mode
);

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------

    typedef struct packed {
        mrr_pkg::mrr_phase_type phase;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [CHOICE_WIDTH-1:0] choice_first;
        logic [CHOICE_WIDTH-1:0] choice_second;
        logic [AUX_COUNT-1:0] pin_cfg;
        logic [AUX_COUNT-1:0] enable;
        logic [AUX_COUNT-1:0] ratio;
        logic [AUX_COUNT+1:0] fresh;
    } mrr_state_type;

    mrr_state_type state;
    mrr_state_type next_state;

    logic load_diag_first;
    logic load_diag_second;
    logic [AUX_COUNT-1:0] load_aux;
    logic [15:0] diag_first_word;
    logic [15:0] diag_second_word;
    logic [15:0] aux_word [AUX_COUNT];
    logic [AUX_COUNT+1:0] fresh_set;
    logic complete;
    logic [7:0] access_index;

    // ---------------------------------------------------------------
    // Decoding
    // ---------------------------------------------------------------

    // Word index of an address; an address above the decoded range maps to an unused index.
    function automatic logic [7:0] mrr_index(input logic [ADDR_WIDTH-1:0] addr);
        logic [ADDR_WIDTH-1:0] word_addr;
        word_addr = addr >> 2;
        if (word_addr > ADDR_WIDTH'(8'hff)) begin
            mrr_index = 8'hff;
        end else begin
            mrr_index = word_addr[7:0];
        end
    endfunction

    // True when an index names a register this block holds.
    function automatic logic mrr_mapped(input logic [7:0] idx);
        mrr_mapped = (idx == `MRR_IDX_DIAG_FIRST) || (idx == `MRR_IDX_DIAG_SECOND)
            || (idx == `MRR_IDX_AUX_ZERO) || (idx == `MRR_IDX_AUX_ONE)
            || (idx == `MRR_IDX_AUX_TWO) || (idx == `MRR_IDX_DIAG_CONFIG)
            || (idx == `MRR_IDX_SIDE_CONFIG) || (idx == `MRR_IDX_FRESH);
    endfunction

    assign access_index = mrr_index(paddr);

    // The transfer completes on the edge where the master sees pready.
    assign complete = (state.phase == mrr_pkg::MRR_PHASE_DONE) && psel && penable;

    // ---------------------------------------------------------------
    // Result storage
    // ---------------------------------------------------------------

    // Route each converter result to the slot that wants it.
    mrr_sample_match #(
        .AUX_COUNT(AUX_COUNT),
        .CHOICE_WIDTH(CHOICE_WIDTH)
    ) u_match (
        .sample(sample),
        .diag_choice_first(state.choice_first),
        .diag_choice_second(state.choice_second),
        .side_pin_config(state.pin_cfg),
        .side_measure_enable(state.enable),
        .load_diag_first(load_diag_first),
        .load_diag_second(load_diag_second),
        .load_aux(load_aux)
    );

    // Diagnostic slots are always visible.
    mrr_result_reg u_diag_first (
        .pclk(pclk),
        .presetn(presetn),
        .load(load_diag_first),
        .data(sample.data),
        .visible(1'b1),
        .word(diag_first_word)
    );

    mrr_result_reg u_diag_second (
        .pclk(pclk),
        .presetn(presetn),
        .load(load_diag_second),
        .data(sample.data),
        .visible(1'b1),
        .word(diag_second_word)
    );

    // One auxiliary slot per channel, hidden unless its pin is analog.
    genvar n;
    generate
        for (n = 0; n < AUX_COUNT; n = n + 1) begin : g_aux
            mrr_result_reg u_aux (
                .pclk(pclk),
                .presetn(presetn),
                .load(load_aux[n]),
                .data(sample.data),
                .visible(state.pin_cfg[n]),
                .word(aux_word[n])
            );
        end
    endgenerate

    // Events that mark a slot as holding a new result.
    assign fresh_set = {load_aux, load_diag_second, load_diag_first};

    // ---------------------------------------------------------------
    // Bus slave and settings
    // ---------------------------------------------------------------

    // Answer each access one cycle after its access phase begins.
    always_comb begin
        next_state = state;
        next_state.fresh = state.fresh;
        unique case (state.phase)
            mrr_pkg::MRR_PHASE_IDLE: begin
                next_state.ready = 1'b0;
                next_state.err = 1'b0;
                if (psel && penable) begin
                    next_state.phase = mrr_pkg::MRR_PHASE_DONE;
                    next_state.ready = 1'b1;
                    next_state.err = !mrr_mapped(access_index);
                    next_state.rdata = 32'h0000_0000;
                    if (!pwrite) begin
                        // Read data is formed here and held until the transfer completes.
                        case (access_index)
                            `MRR_IDX_DIAG_FIRST: next_state.rdata = {16'h0000, diag_first_word};
                            `MRR_IDX_DIAG_SECOND: next_state.rdata = {16'h0000, diag_second_word};
                            `MRR_IDX_AUX_ZERO: next_state.rdata = {16'h0000, aux_word[0]};
                            `MRR_IDX_AUX_ONE: next_state.rdata = {16'h0000, aux_word[1]};
                            `MRR_IDX_AUX_TWO: next_state.rdata = {16'h0000, aux_word[2]};
                            `MRR_IDX_DIAG_CONFIG: begin
                                next_state.rdata[`MRR_DIAG_FIRST_LSB +: CHOICE_WIDTH] = state.choice_first;
                                next_state.rdata[`MRR_DIAG_SECOND_LSB +: CHOICE_WIDTH] = state.choice_second;
                            end
                            `MRR_IDX_SIDE_CONFIG: begin
                                next_state.rdata[`MRR_PIN_CFG_LSB +: AUX_COUNT] = state.pin_cfg;
                                next_state.rdata[`MRR_ENABLE_LSB +: AUX_COUNT] = state.enable;
                                next_state.rdata[`MRR_RATIO_LSB +: AUX_COUNT] = state.ratio;
                            end
                            `MRR_IDX_FRESH: next_state.rdata[AUX_COUNT+1:0] = state.fresh;
                            default: next_state.rdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            mrr_pkg::MRR_PHASE_DONE: begin
                next_state.phase = mrr_pkg::MRR_PHASE_IDLE;
                next_state.ready = 1'b0;
                next_state.err = 1'b0;
                if (complete && pwrite) begin
                    // Only the setting registers take writes; result registers ignore them.
                    case (access_index)
                        `MRR_IDX_DIAG_CONFIG: begin
                            next_state.choice_first = pwdata[`MRR_DIAG_FIRST_LSB +: CHOICE_WIDTH];
                            next_state.choice_second = pwdata[`MRR_DIAG_SECOND_LSB +: CHOICE_WIDTH];
                        end
                        `MRR_IDX_SIDE_CONFIG: begin
                            next_state.pin_cfg = pwdata[`MRR_PIN_CFG_LSB +: AUX_COUNT];
                            next_state.enable = pwdata[`MRR_ENABLE_LSB +: AUX_COUNT];
                            next_state.ratio = pwdata[`MRR_RATIO_LSB +: AUX_COUNT];
                        end
                        default: next_state.rdata = state.rdata;
                    endcase
                end
                if (complete && !pwrite && (access_index == `MRR_IDX_FRESH)) begin
                    // Clear only what was reported; a new result in this cycle survives.
                    next_state.fresh = state.fresh & ~state.rdata[AUX_COUNT+1:0];
                end
            end
        endcase
        // Setting a fresh flag wins over clearing it.
        next_state.fresh = next_state.fresh | fresh_set;
    end

    // Register the whole state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.phase <= mrr_pkg::MRR_PHASE_IDLE;
            state.rdata <= 32'h0000_0000;
            state.ready <= 1'b0;
            state.err <= 1'b0;
            state.choice_first <= CHOICE_WIDTH'(`MRR_DIAG_CONFIG_RESET >> `MRR_DIAG_FIRST_LSB);
            state.choice_second <= CHOICE_WIDTH'(`MRR_DIAG_CONFIG_RESET >> `MRR_DIAG_SECOND_LSB);
            state.pin_cfg <= AUX_COUNT'(`MRR_SIDE_CONFIG_RESET >> `MRR_PIN_CFG_LSB);
            state.enable <= AUX_COUNT'(`MRR_SIDE_CONFIG_RESET >> `MRR_ENABLE_LSB);
            state.ratio <= AUX_COUNT'(`MRR_SIDE_CONFIG_RESET >> `MRR_RATIO_LSB);
            state.fresh <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    // Every output is a flip-flop of the state.
    assign prdata = state.rdata;
    assign pready = state.ready;
    assign pslverr = state.err;
    assign diag_choice_first = state.choice_first;
    assign diag_choice_second = state.choice_second;
    assign side_pin_config = state.pin_cfg;
    assign side_measure_enable = state.enable;
    // The converter uses this to pick the supply or the reference as full scale.
    assign side_ratio_mode = state.ratio;

endmodule

// File: mrr_readback_chk.sv
`timescale 1ns/1ps

module mrr_readback_chk #(
    parameter int ADDR_WIDTH = 12,
    parameter int AUX_COUNT = 3,
    parameter int CHOICE_WIDTH = 4
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Settings.
    input wire logic [CHOICE_WIDTH-1:0] diag_choice_first,
    input wire logic [CHOICE_WIDTH-1:0] diag_choice_second,
    input wire logic [AUX_COUNT-1:0] side_pin_config,
    input wire logic [AUX_COUNT-1:0] side_ratio_mode
);
    // ---------------------------------------------------------------
    // Bus timing and register contents
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A result register read never shows bits outside the result field.
    chk_result_pad_zero: assert property (pready && !pwrite && (paddr >> 2) >= 8'h57 && (paddr >> 2) <= 8'h5b
        |-> prdata[1:0] == 2'b00 && prdata[31:16] == 16'h0000) else $error("result padding bits not zero");
    // Writes to result registers complete without an error.
    chk_result_write_ok: assert property (pready && pwrite && (paddr >> 2) >= 8'h57 && (paddr >> 2) <= 8'h5b
        |-> !pslverr) else $error("write to result register flagged");
    // Aux channel two (0x16c) reads zero when its pin is not analog, even with a stored result behind it.
    chk_aux_zero_pin: assert property (pready && !pwrite && paddr == 12'h16c && !side_pin_config[2]
        |-> prdata == 32'h0000_0000) else $error("unconfigured aux reads nonzero");
    // Every access phase is answered one cycle after it starts, for one cycle.
    chk_ready_timing: assert property ($rose(penable) && psel |=> pready ##1 !pready)
        else $error("pready timing wrong");
    // Places above the decoded range answer with an error and zero data.
    chk_unmapped_err: assert property (pready && (paddr >> 2) > 8'hff |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    // Error only accompanies a completion.
    chk_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    // Diagnostic selections follow a completed configuration write.
    chk_diag_choice: assert property (psel && penable && pready && pwrite && paddr == 12'h180
        |=> diag_choice_first == $past(pwdata[3:0]) && diag_choice_second == $past(pwdata[11:8]))
        else $error("diagnostic choice not taken");
    // The per-channel full-scale mode follows a completed side configuration write.
    chk_ratio_mode: assert property (psel && penable && pready && pwrite && paddr == 12'h184
        |=> side_ratio_mode == $past(pwdata[18:16]) && side_pin_config == $past(pwdata[2:0]))
        else $error("ratio mode not taken");
endmodule

bind mrr_readback mrr_readback_chk #(.ADDR_WIDTH(ADDR_WIDTH), .AUX_COUNT(AUX_COUNT), .CHOICE_WIDTH(CHOICE_WIDTH))
    u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .diag_choice_first(diag_choice_first),
    .diag_choice_second(diag_choice_second), .side_pin_config(side_pin_config), .side_ratio_mode(side_ratio_mode));

// File: mrr_readback_tb_top.sv
`timescale 1ns/1ps

module mrr_readback_tb_top;
    // ---------------------------------------------------------------
    // Signals and the unit under test
    // ---------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mrr_pkg::mrr_sample_type sample = '0;
    logic [3:0] diag_choice_first;
    logic [3:0] diag_choice_second;
    logic [2:0] side_pin_config;
    logic [2:0] side_measure_enable;
    logic [2:0] side_ratio_mode;
    int err_count = 0;
    int checks_done = 0;

    mrr_readback u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample(sample),
        .diag_choice_first(diag_choice_first), .diag_choice_second(diag_choice_second),
        .side_pin_config(side_pin_config), .side_measure_enable(side_measure_enable),
        .side_ratio_mode(side_ratio_mode));

    // The clock toggles every half period of 2.5 ns.
    always #2.5 pclk = ~pclk;

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Builds the word that a result register shows for a 14-bit code.
    function automatic logic [31:0] res(input logic [13:0] d);
        return {16'h0000, d, 2'b00};
    endfunction

    // Runs one APB transfer and returns the data and error taken at completion.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Waits as long as the slave needs; only the watchdog ends a hang.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a register and compares data and error flag.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask

    // Writes a register and expects no error.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0000_0000);
        // Lets the committed setting reach the outputs before the caller looks.
        @(posedge pclk);
    endtask

    // Offers one converter result for a single cycle.
    task automatic send(input mrr_pkg::mrr_kind_type k, input logic [3:0] i, input logic [13:0] d);
        @(posedge pclk);
        sample <= '{1'b1, k, i, d};
        @(posedge pclk);
        sample.valid <= 1'b0;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    // Result and setting registers read zero after reset, and the result registers ignore writes.
    task automatic t_reset_and_ro;
        for (int i = 0; i < 5; i++) rd(12'h15c + 12'(4 * i), 32'h0000_0000, 1'b0);
        rd(12'h180, 32'h0000_0000, 1'b0);
        rd(12'h184, 32'h0000_0000, 1'b0);
        for (int i = 0; i < 5; i++) wr(12'h15c + 12'(4 * i), 32'hffff_ffff);
        for (int i = 0; i < 5; i++) rd(12'h15c + 12'(4 * i), 32'h0000_0000, 1'b0);
        rd(12'hffc, 32'h0000_0000, 1'b1);
    endtask

    // Diagnostic results land only in the register whose selection matches.
    task automatic t_diag;
        wr(12'h180, 32'h0000_0503);
        chk({28'h0, diag_choice_first}, 32'h0000_0003);
        chk({28'h0, diag_choice_second}, 32'h0000_0005);
        send(mrr_pkg::MRR_KIND_DIAG, 4'h3, 14'h3fff);
        rd(12'h15c, res(14'h3fff), 1'b0);
        rd(12'h160, 32'h0000_0000, 1'b0);
        send(mrr_pkg::MRR_KIND_DIAG, 4'h5, 14'h1234);
        rd(12'h160, res(14'h1234), 1'b0);
        send(mrr_pkg::MRR_KIND_DIAG, 4'h3, 14'h0001);
        send(mrr_pkg::MRR_KIND_DIAG, 4'h7, 14'h2222);
        rd(12'h15c, res(14'h0001), 1'b0);
        rd(12'h160, res(14'h1234), 1'b0);
        rd(12'h188, 32'h0000_0003, 1'b0);
        rd(12'h188, 32'h0000_0000, 1'b0);
    endtask

    // Aux results follow pin configuration and enables.
    task automatic t_aux;
        wr(12'h184, 32'h0005_0707);
        chk({29'h0, side_ratio_mode}, 32'h0000_0005);
        chk({29'h0, side_measure_enable}, 32'h0000_0007);
        chk({29'h0, side_pin_config}, 32'h0000_0007);
        for (int n = 0; n < 3; n++) send(mrr_pkg::MRR_KIND_AUX, 4'(n), 14'h0100 + 14'(n));
        for (int n = 0; n < 3; n++) rd(12'h164 + 12'(4 * n), res(14'h0100 + 14'(n)), 1'b0);
        wr(12'h184, 32'h0000_0507);
        send(mrr_pkg::MRR_KIND_AUX, 4'h1, 14'h2aaa);
        send(mrr_pkg::MRR_KIND_AUX, 4'h0, 14'h2aaa);
        rd(12'h168, res(14'h0101), 1'b0);
        rd(12'h164, res(14'h2aaa), 1'b0);
        wr(12'h184, 32'h0000_0303);
        rd(12'h16c, 32'h0000_0000, 1'b0);
        wr(12'h184, 32'h0000_0707);
        rd(12'h16c, res(14'h0102), 1'b0);
    endtask

    // ---------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ---------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("checks done %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run of under two hundred cycles.
    initial begin
        #20000;
        err_count++;
        test_done();
    end

    // Resets for three cycles, then runs every scenario.
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_and_ro();
        t_diag();
        t_aux();
        test_done();
    end
endmodule

// File: mrr_result_reg.sv
`timescale 1ns/1ps
`include "mrr_cfg.svh"

module mrr_result_reg (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Load side.
    input wire logic load,
    input wire logic [`MRR_RESULT_WIDTH-1:0] data,
    // Read side.
    input wire logic visible,
    output logic [15:0] word
);

    typedef struct packed {
        logic [`MRR_RESULT_WIDTH-1:0] held;
    } mrr_slot_type;

    mrr_slot_type state;
    mrr_slot_type next_state;

    // Keep the last result; a skipped channel simply sees no load.
    always_comb begin
        next_state = state;
        if (load) begin
            next_state.held = data;
        end
    end

    // Result storage starts at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.held <= `MRR_RESULT_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Left-justify the result, low bits zero, hidden when the pin is not analog.
    assign word = visible ? {state.held, 2'b00} : 16'h0000;

endmodule

// File: mrr_sample_match.sv
`timescale 1ns/1ps
`include "mrr_cfg.svh"

module mrr_sample_match #(
    parameter int AUX_COUNT = `MRR_AUX_COUNT,
    parameter int CHOICE_WIDTH = `MRR_CHOICE_WIDTH
) (
    // Converter result.
    input wire mrr_pkg::mrr_sample_type sample,
    // Settings.
    input wire logic [CHOICE_WIDTH-1:0] diag_choice_first,
    input wire logic [CHOICE_WIDTH-1:0] diag_choice_second,
    input wire logic [AUX_COUNT-1:0] side_pin_config,
    input wire logic [AUX_COUNT-1:0] side_measure_enable,
    // Loads.
    output logic load_diag_first,
    output logic load_diag_second,
    output logic [AUX_COUNT-1:0] load_aux
);

    logic is_diag;
    logic is_aux;

    // Classify the strobe.
    assign is_diag = sample.valid && (sample.kind == mrr_pkg::MRR_KIND_DIAG);
    assign is_aux = sample.valid && (sample.kind == mrr_pkg::MRR_KIND_AUX);

    // A diagnostic result lands where its code matches the selection.
    assign load_diag_first = is_diag && (sample.index == `MRR_INDEX_WIDTH'(diag_choice_first));
    assign load_diag_second = is_diag && (sample.index == `MRR_INDEX_WIDTH'(diag_choice_second));

    // An auxiliary result lands only on an analog, enabled channel.
    genvar n;
    generate
        for (n = 0; n < AUX_COUNT; n = n + 1) begin : g_aux
            assign load_aux[n] = is_aux && (sample.index == `MRR_INDEX_WIDTH'(n))
                && side_pin_config[n] && side_measure_enable[n];
        end
    endgenerate

endmodule
